// ### core/cwg_core.sv
// Dead-band, steering and auto-shutdown core with an AXI4-Lite register slave.
// Notes on behaviour
// - Rise dead band delays A half, B full
// - Dead bands double-buffered; direct when disabled
// - Load request transfers buffers at input fall
// - Fall dead band delays B half, D full
// - Too short input state gives no pulse
// - Dead-band jitter at most one clock
// - Direction bit acts at next input rise
// - Direction change delays first modulated pulse only
// - Steered outputs carry data, others override level
// - Polarity applies only to steered outputs
// - Shutdown overrides only steered outputs
// - Asynchronous steering changes take effect immediately
// - Synchronous steering changes wait for input rise
// - Software shutdown flag forces shutdown state
// - Auto-restart clears software flag, resumes at rise
// - Enabled active-low sources force overrides immediately
// - Sources level-sensitive; shutdown holds while active
// - High and low override codes drive pins, polarity ignored
// - Software clear fails while sources active
// - Auto-restart clears flag when sources quiet
// - Keeps running asleep; fast oscillator request
// - Dead band counts clocks up to value
// - Three-bit mode decode, two codes reserved
// - Clock select bit gates fast oscillator request
`timescale 1ns/1ps
`default_nettype none
module cwg_core
  import cwg_pkg::*;
#(
  parameter int DBW = DB_W
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_MOD_IN,
  input wire logic I_PIN_SD_N,
  input wire logic I_TMR2_SD_N,
  input wire logic I_CMP1_SD_N,
  input wire logic I_CMP2_SD_N,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_OUT_A,
  output logic O_OUT_B,
  output logic O_OUT_C,
  output logic O_OUT_D,
  output logic O_OE_A,
  output logic O_OE_B,
  output logic O_OE_C,
  output logic O_OE_D,
  output logic O_FAST_OSC_KEEP
);
  // Override level as {drive enable, value}; code 00 gives the pin's inactive level.
  function automatic logic [1:0] ovr_lvl(input logic [1:0] ls, input logic pol);
    case (ls)
      LS_HIGH: ovr_lvl = 2'h3;
      LS_LOW: ovr_lvl = 2'h2;
      LS_FLOAT: ovr_lvl = 2'h0;
      default: ovr_lvl = {1'b1, pol};
    endcase
  endfunction

  function automatic logic is_map(input logic [ADDR_W-1:0] a);
    is_map = (a[1:0] == 2'h0);
  endfunction

  logic en_r, ld_r, cs_r, sd_r, ren_r, hold_r;
  logic [2:0] mode_r;
  logic [3:0] pol_r, ovr_r, str_r, str_act_r, as_en_r;
  logic [1:0] override_level_b_d_r, override_level_a_c_r;
  logic [DBW-1:0] dbr_buf_r, dbf_buf_r, dbr_act_r, dbf_act_r, cnt_r;
  logic in_r, prev_r, rise, fall;
  logic pp_cur_r, pp_nxt_r, dir_r, chg_r;
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r, rd_nxt;
  logic wstrb_r, wr_fire, we;
  logic [31:0] rdata_r;
  logic [3:0] out_r, oe_r, out_nxt, oe_nxt;

  // Write channel: address and data are taken in either order.
  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  assign we = wr_fire & wstrb_r & is_map(awaddr_r);

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 1'b0;
    end else begin
      if (I_AWVALID && awready_r) begin
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= I_AWADDR;
      end
      if (I_WVALID && wready_r) begin
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= I_WDATA[7:0];
        wstrb_r <= I_WSTRB[0];
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= is_map(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && I_BREADY) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_nxt = 8'h00;
    case (I_ARADDR)
      MAIN_CTRL_OFS: rd_nxt = {en_r, ld_r, 3'h0, mode_r};
      POL_CTRL_OFS: rd_nxt = {2'h0, in_r, 1'b0, pol_r};
      RISE_DB_OFS: rd_nxt = {2'h0, dbr_buf_r};
      FALL_DB_OFS: rd_nxt = {2'h0, dbf_buf_r};
      SD_CTRL_OFS: rd_nxt = {sd_r, ren_r, override_level_b_d_r, override_level_a_c_r, 2'h0};
      SD_SRC_OFS: rd_nxt = {4'h0, as_en_r};
      STEER_CTRL_OFS: rd_nxt = {ovr_r, str_r};
      CLK_SEL_OFS: rd_nxt = {7'h00, cs_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (I_ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_nxt};
      rresp_r <= is_map(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && I_RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Plain control registers.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      en_r <= 1'b0;
      mode_r <= 3'h0;
      pol_r <= 4'h0;
      ren_r <= 1'b0;
      override_level_b_d_r <= LS_RST;
      override_level_a_c_r <= LS_RST;
      as_en_r <= 4'h0;
      ovr_r <= 4'h0;
      str_r <= 4'h0;
      cs_r <= 1'b0;
    end else if (we) begin
      case (awaddr_r)
        MAIN_CTRL_OFS: begin
          en_r <= wdata_r[EN_BIT];
          mode_r <= wdata_r[2:0];
        end
        POL_CTRL_OFS: pol_r <= wdata_r[3:0];
        SD_CTRL_OFS: begin
          ren_r <= wdata_r[REN_BIT];
          override_level_b_d_r <= wdata_r[OVERRIDE_LEVEL_B_D_LO+:2];
          override_level_a_c_r <= wdata_r[OVERRIDE_LEVEL_A_C_LO+:2];
        end
        SD_SRC_OFS: as_en_r <= wdata_r[3:0];
        STEER_CTRL_OFS: begin
          ovr_r <= wdata_r[OVR_LO+:4];
          str_r <= wdata_r[3:0];
        end
        CLK_SEL_OFS: cs_r <= wdata_r[0];
        default: ;
      endcase
    end
  end

  // Input edge detection; the input is taken as synchronous to the clock.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      in_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      in_r <= I_MOD_IN;
      prev_r <= in_r;
    end
  end
  assign rise = in_r & ~prev_r;
  assign fall = ~in_r & prev_r;

  // One counter times whichever dead band is running, since only one runs per input state.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || rise || fall) begin
      cnt_r <= '0;
    end else if (cnt_r != {DBW{1'b1}}) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Dead-band buffers; the load request is accepted only once the module runs.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      dbr_buf_r <= '0;
      dbf_buf_r <= '0;
      dbr_act_r <= '0;
      dbf_act_r <= '0;
      ld_r <= 1'b0;
    end else begin
      if (we && awaddr_r == RISE_DB_OFS) begin
        dbr_buf_r <= wdata_r[DBW-1:0];
        if (!en_r) dbr_act_r <= wdata_r[DBW-1:0];
      end
      if (we && awaddr_r == FALL_DB_OFS) begin
        dbf_buf_r <= wdata_r[DBW-1:0];
        if (!en_r) dbf_act_r <= wdata_r[DBW-1:0];
      end
      if (ld_r && fall) begin
        dbr_act_r <= dbr_buf_r;
        dbf_act_r <= dbf_buf_r;
        ld_r <= 1'b0;
      end
      if (!en_r) begin
        ld_r <= 1'b0;
      end
      if (we && awaddr_r == MAIN_CTRL_OFS && en_r && wdata_r[LD_BIT]) begin
        ld_r <= 1'b1;
      end
    end
  end

  // Shutdown flag: a hardware set wins over any clear in the same cycle.
  logic src_act, sw_set, sw_clr, shut, pp_rst;
  assign src_act = |(as_en_r & ~{I_CMP2_SD_N, I_CMP1_SD_N, I_TMR2_SD_N, I_PIN_SD_N});
  assign sw_set = we && awaddr_r == SD_CTRL_OFS && wdata_r[SD_BIT];
  assign sw_clr = we && awaddr_r == SD_CTRL_OFS && !wdata_r[SD_BIT];

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      sd_r <= 1'b0;
    end else if (src_act || sw_set) begin
      sd_r <= 1'b1;
    end else if (sw_clr || ren_r) begin
      sd_r <= 1'b0;
    end
  end

  // Overrides stay until the first input rise after the flag has cleared.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      hold_r <= 1'b0;
    end else if (sd_r || src_act) begin
      hold_r <= 1'b1;
    end else if (rise) begin
      hold_r <= 1'b0;
    end
  end
  assign shut = sd_r | src_act | (hold_r & ~rise);
  assign pp_rst = ~en_r | shut;

  // Push-pull sequencer and full-bridge direction, both sampled at the input rise.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || pp_rst) begin
      pp_cur_r <= 1'b0;
      pp_nxt_r <= 1'b0;
    end else if (rise) begin
      pp_cur_r <= pp_nxt_r;
      pp_nxt_r <= ~pp_nxt_r;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      dir_r <= 1'b0;
      chg_r <= 1'b0;
      str_act_r <= 4'h0;
    end else begin
      if (rise) begin
        dir_r <= mode_r[0];
        chg_r <= (mode_r[0] != dir_r);
        str_act_r <= str_r;
      end
      if (mode_r != MODE_SYNC_STEER) begin
        str_act_r <= str_r;
      end
    end
  end

  // Output shaping; every pin is registered before it leaves the block.
  logic pp_sel, dir, chg, mod_ok, a_hb, b_hb;
  logic [3:0] str_eff, act, lvl_val, lvl_oe, shut_msk;
  logic [1:0] lv_ac, lv_bd;
  assign pp_sel = rise ? pp_nxt_r : pp_cur_r;
  assign dir = rise ? mode_r[0] : dir_r;
  assign chg = rise ? (mode_r[0] != dir_r) : chg_r;
  assign str_eff = (mode_r == MODE_SYNC_STEER && rise) ? str_r : str_act_r;
  // Edges are seen on a clock sample, so the dead band may stretch by one clock.
  assign a_hb = in_r & ~rise & (cnt_r >= dbr_act_r);
  assign b_hb = ~in_r & ~fall & (cnt_r >= dbf_act_r);
  assign mod_ok = ~chg | (~rise & (cnt_r >= (dir ? dbr_act_r : dbf_act_r)));
  assign lv_ac = ovr_lvl(override_level_a_c_r, 1'b0);
  assign lv_bd = ovr_lvl(override_level_b_d_r, 1'b0);

  always_comb begin
    act = 4'h0;
    shut_msk = 4'hf;
    case (mode_r)
      MODE_STEER, MODE_SYNC_STEER: begin
        act = {4{in_r}};
        shut_msk = str_eff;
      end
      MODE_FB_FWD, MODE_FB_REV: begin
        if (dir) begin
          act = {1'b0, 1'b1, in_r & mod_ok, 1'b0};
        end else begin
          act = {in_r & mod_ok, 1'b0, 1'b0, 1'b1};
        end
      end
      MODE_HALF: act = {b_hb, a_hb, b_hb, a_hb};
      MODE_PUSH: act = {in_r & pp_sel, in_r & ~pp_sel, in_r & pp_sel, in_r & ~pp_sel};
      default: act = 4'h0;
    endcase
  end

  always_comb begin
    lvl_val = {lv_bd[0], lv_ac[0], lv_bd[0], lv_ac[0]};
    lvl_oe = {lv_bd[1], lv_ac[1], lv_bd[1], lv_ac[1]};
    if (override_level_b_d_r == 2'h0) lvl_val[3] = pol_r[3];
    if (override_level_b_d_r == 2'h0) lvl_val[1] = pol_r[1];
    if (override_level_a_c_r == 2'h0) lvl_val[2] = pol_r[2];
    if (override_level_a_c_r == 2'h0) lvl_val[0] = pol_r[0];
    for (int i = 0; i < 4; i++) begin
      out_nxt[i] = act[i] ^ pol_r[i];
      oe_nxt[i] = 1'b1;
      if ((mode_r == MODE_STEER || mode_r == MODE_SYNC_STEER) && !str_eff[i]) begin
        out_nxt[i] = ovr_r[i];
      end
      if (!en_r) begin
        out_nxt[i] = pol_r[i];
      end
      if (shut && (shut_msk[i] || !en_r)) begin
        out_nxt[i] = lvl_val[i];
        oe_nxt[i] = lvl_oe[i];
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      out_r <= 4'h0;
      oe_r <= 4'h0;
      O_FAST_OSC_KEEP <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      O_FAST_OSC_KEEP <= en_r & cs_r & (in_r | prev_r | rise);
    end
  end

  assign O_OUT_A = out_r[0];
  assign O_OUT_B = out_r[1];
  assign O_OUT_C = out_r[2];
  assign O_OUT_D = out_r[3];
  assign O_OE_A = oe_r[0];
  assign O_OE_B = oe_r[1];
  assign O_OE_C = oe_r[2];
  assign O_OE_D = oe_r[3];
  assign O_AWREADY = awready_r;
  assign O_WREADY = wready_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_ARREADY = arready_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;
endmodule
`default_nettype wire

// ### include/cwg_pkg.sv
// Shared constants and types of the complementary waveform dead-band block.
package cwg_pkg;
  localparam int ADDR_W = 5;
  localparam int DB_W = 6;
  localparam logic [ADDR_W-1:0] MAIN_CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] POL_CTRL_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] RISE_DB_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] FALL_DB_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] SD_CTRL_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] SD_SRC_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] STEER_CTRL_OFS = 5'h18;
  localparam logic [ADDR_W-1:0] CLK_SEL_OFS = 5'h1c;
  localparam int EN_BIT = 7;
  localparam int LD_BIT = 6;
  localparam int IN_BIT = 5;
  localparam int SD_BIT = 7;
  localparam int REN_BIT = 6;
  localparam int OVERRIDE_LEVEL_B_D_LO = 4;
  localparam int OVERRIDE_LEVEL_A_C_LO = 2;
  localparam int OVR_LO = 4;
  localparam logic [1:0] LS_RST = 2'h1;
  localparam logic [1:0] LS_HIGH = 2'h3;
  localparam logic [1:0] LS_LOW = 2'h2;
  localparam logic [1:0] LS_FLOAT = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_STEER,
    MODE_SYNC_STEER,
    MODE_FB_FWD,
    MODE_FB_REV,
    MODE_HALF,
    MODE_PUSH
  } cwg_mode_t;
endpackage

// ### bench/cwg_core_asserts.sv
// Checker of bus handshakes and oscillator request at the core's ports.
`timescale 1ns/1ps
`default_nettype none
module cwg_chk
  import cwg_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_MOD_IN,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_FAST_OSC_KEEP
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  property p_aw_take; I_AWVALID && O_AWREADY |=> !O_AWREADY; endproperty
  a_aw_take: assert property (p_aw_take) else $error("address ready after take");
  property p_b_next; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
  a_b_next: assert property (p_b_next) else $error("write answer late");
  property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_err;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && I_AWADDR[1:0] != 2'h0
      |-> ##2 O_BRESP == RESP_SLVERR;
  endproperty
  a_w_err: assert property (p_w_err) else $error("misaligned write not refused");
  property p_r_next; I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY; endproperty
  a_r_next: assert property (p_r_next) else $error("read answer late");
  property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_err;
    I_ARVALID && O_ARREADY && I_ARADDR[1:0] != 2'h0 |=> O_RRESP == RESP_SLVERR;
  endproperty
  a_r_err: assert property (p_r_err) else $error("misaligned read not refused");
  property p_r_hi; O_RVALID |-> O_RDATA[31:8] == 24'h0; endproperty
  a_r_hi: assert property (p_r_hi) else $error("upper read bits set");
  property p_osc;
    O_FAST_OSC_KEEP |-> $past(I_MOD_IN) || $past(I_MOD_IN, 2) || $past(I_MOD_IN, 3);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator kept with quiet input");
  c_wr: cover property (O_BVALID && I_BREADY);
  c_rd: cover property (O_RVALID && I_RREADY);
  c_osc: cover property ($rose(O_FAST_OSC_KEEP));
endmodule
bind cwg_core cwg_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_MOD_IN(I_MOD_IN),
  .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
  .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_FAST_OSC_KEEP(O_FAST_OSC_KEEP));
`default_nettype wire

// ### bench/cwg_drv_model.sv
// Switch driver inputs seen from the four output pins.
`timescale 1ns/1ps
`default_nettype none
module cwg_drv (
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_oe,
  output logic [3:0] o_pin
);
  // The driver inputs carry pull-downs, so an undriven pin reads low, never a stale level.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pin[k] = i_oe[k] ? i_out[k] : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### bench/test_cwg_core.sv
// Self-checking bench of the dead-band, steering and shutdown core.
`timescale 1ns/1ps
`default_nettype none
module test_cwg_core;
  import cwg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, mod_in = 1'b0, awv = 1'b0, wv = 1'b0;
  logic bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [3:0] sd_n = 4'hf, pol, str, ovr, ex;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, r;
  logic [1:0] resp;
  wire logic w_awr, w_wr, w_bv, w_arr, w_rv, fok;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rd_w;
  wire logic [3:0] outs, oes, pins;
  int mismatches = 0, checked = 0, cyc = 0, d1, d2, d3, n;
  always #25 clk = ~clk;
  cwg_core DUT (.I_REF_CLK(clk), .I_RST(rst), .I_MOD_IN(mod_in), .I_PIN_SD_N(sd_n[0]),
    .I_TMR2_SD_N(sd_n[1]), .I_CMP1_SD_N(sd_n[2]), .I_CMP2_SD_N(sd_n[3]),
    .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(w_awr), .I_WDATA(wdata),
    .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(w_wr), .O_BRESP(bresp), .O_BVALID(w_bv),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(w_arr),
    .O_RDATA(rd_w), .O_RRESP(rresp), .O_RVALID(w_rv), .I_RREADY(rready),
    .O_OUT_A(outs[0]), .O_OUT_B(outs[1]), .O_OUT_C(outs[2]), .O_OUT_D(outs[3]),
    .O_OE_A(oes[0]), .O_OE_B(oes[1]), .O_OE_C(oes[2]), .O_OE_D(oes[3]),
    .O_FAST_OSC_KEEP(fok));
  cwg_drv u_drv (.i_out(outs), .i_oe(oes), .o_pin(pins));
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_pin(input logic [3:0] e);
    checked++;
    if (pins !== e) begin
      mismatches++;
      $display("ERROR pins expected %h seen %h", e, pins);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (w_awr) awv <= 1'b0;
      if (w_wr) wv <= 1'b0;
    end while (!w_bv);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (w_arr) arv <= 1'b0;
    end while (!w_rv);
    r = rd_w;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Counts edges from an input change until pin k reads high, giving up after 100.
  task automatic meas(input int k);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pins[k] !== 1'b1 && n < 100);
  endtask
  task automatic drive_in(input logic v, input int w);
    @(posedge clk);
    mod_in <= v;
    repeat (w) @(posedge clk);
  endtask
  function automatic logic [3:0] sexp(input logic i);
    for (int k = 0; k < 4; k++) sexp[k] = str[k] ? i ^ pol[k] : ovr[k];
  endfunction
  initial begin
    void'($urandom(32'hca4a));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(SD_CTRL_OFS);
    cmp_reg("shutdown reset", 32'h14, r);
    rd(5'h03);
    cmp_reg("read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(5'h06, 8'hff);
    cmp_reg("write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    for (int m = 0; m < 8; m++) begin
      wr(MAIN_CTRL_OFS, 8'(m));
      rd(MAIN_CTRL_OFS);
      cmp_reg("mode", 32'(m), r);
    end
    d1 = $urandom;
    wr(RISE_DB_OFS, 8'(d1));
    rd(RISE_DB_OFS);
    cmp_reg("rise db", 32'(d1 & 63), r);
    // Start from shutdown, then clear the flag once enabled.
    wr(SD_CTRL_OFS, 8'hb8);
    wr(MAIN_CTRL_OFS, 8'h80);
    wr(SD_CTRL_OFS, 8'h38);
    drive_in(1'b1, 4);
    for (int i = 0; i < 8; i++) begin
      {pol, str, ovr} = 12'($urandom);
      wr(POL_CTRL_OFS, {4'h0, pol});
      wr(STEER_CTRL_OFS, {ovr, str});
      drive_in(1'($urandom), 4);
      cmp_pin(sexp(mod_in));
    end
    // Synchronous steering keeps the old selection until the next input rise.
    wr(MAIN_CTRL_OFS, 8'h81);
    drive_in(1'b0, 4);
    ex = sexp(1'b0);
    str = ~str;
    wr(STEER_CTRL_OFS, {ovr, str});
    cmp_pin(ex);
    drive_in(1'b1, 4);
    cmp_pin(sexp(1'b1));
    wr(MAIN_CTRL_OFS, 8'h80);
    str = 4'h3;
    wr(STEER_CTRL_OFS, {ovr, str});
    ex = {ovr[3:2], 2'b10};
    for (int i = 3; i >= 0; i--) begin
      wr(SD_SRC_OFS, 8'(1 << i));
      sd_n[i] <= 1'b0;
      repeat (4) @(posedge clk);
      cmp_pin(ex);
      wr(SD_CTRL_OFS, 8'h38);
      rd(SD_CTRL_OFS);
      cmp_reg("held shutdown", 32'hb8, r);
      if (i > 0) begin
        sd_n <= 4'hf;
        wr(SD_CTRL_OFS, 8'h38);
        drive_in(1'b0, 2);
        drive_in(1'b1, 4);
        cmp_pin(sexp(1'b1));
      end
    end
    drive_in(1'b0, 2);
    sd_n <= 4'hf;
    wr(SD_CTRL_OFS, 8'h38);
    drive_in(1'b0, 4);
    cmp_pin(ex);
    drive_in(1'b1, 4);
    cmp_pin(sexp(1'b1));
    wr(SD_CTRL_OFS, 8'hf8);
    rd(SD_CTRL_OFS);
    cmp_reg("auto restart", 32'h78, r);
    wr(POL_CTRL_OFS, 8'h00);
    wr(MAIN_CTRL_OFS, 8'h04);
    d1 = 63;
    d2 = $urandom_range(12);
    wr(RISE_DB_OFS, 8'(d1));
    wr(FALL_DB_OFS, 8'(d2));
    wr(MAIN_CTRL_OFS, 8'h84);
    drive_in(1'b0, 6);
    drive_in(1'b1, 0);
    meas(0);
    cmp_reg("rise delay", 32'(4 + d1), 32'(n));
    drive_in(1'b0, 0);
    meas(1);
    cmp_reg("fall delay", 32'(4 + d2), 32'(n));
    d3 = 5 + $urandom_range(7);
    wr(RISE_DB_OFS, 8'(d3));
    wr(MAIN_CTRL_OFS, 8'hc4);
    rd(MAIN_CTRL_OFS);
    cmp_reg("load pending", 32'hc4, r);
    drive_in(1'b1, 70);
    drive_in(1'b0, 8);
    rd(MAIN_CTRL_OFS);
    cmp_reg("load done", 32'h84, r);
    drive_in(1'b1, 3);
    drive_in(1'b0, 0);
    ex = 4'h0;
    repeat (20) begin
      @(posedge clk);
      ex[0] = ex[0] | pins[0];
    end
    cmp_reg("short pulse", 32'h0, {31'h0, ex[0]});
    drive_in(1'b1, 0);
    meas(0);
    cmp_reg("new rise delay", 32'(4 + d3), 32'(n));
    // Push-pull from a floating shutdown: the sequencer restarts on A and C.
    wr(MAIN_CTRL_OFS, 8'h85);
    wr(SD_CTRL_OFS, 8'h94);
    repeat (2) @(posedge clk);
    cmp_reg("float enables", 32'h0, {28'h0, oes});
    cmp_pin(4'h0);
    wr(SD_CTRL_OFS, 8'h14);
    drive_in(1'b0, 4);
    for (int k = 0; k < 4; k++) begin
      drive_in(1'b1, 4);
      cmp_pin(k[0] ? 4'ha : 4'h5);
      drive_in(1'b0, 4);
      cmp_pin(4'h0);
    end
    // Full bridge: the direction left by push-pull is reverse, so forward is a change.
    wr(MAIN_CTRL_OFS, 8'h82);
    drive_in(1'b1, 0);
    meas(3);
    cmp_reg("forward first delay", 32'(4 + d2), 32'(n));
    cmp_pin(4'h9);
    drive_in(1'b0, 4);
    drive_in(1'b1, 0);
    meas(3);
    cmp_reg("forward next delay", 32'h3, 32'(n));
    drive_in(1'b0, 4);
    wr(MAIN_CTRL_OFS, 8'h83);
    cmp_pin(4'h1);
    drive_in(1'b1, 0);
    meas(1);
    cmp_reg("reverse first delay", 32'(4 + d3), 32'(n));
    cmp_pin(4'h6);
    wr(CLK_SEL_OFS, 8'h01);
    repeat (4) @(posedge clk);
    cmp_reg("osc keep", 32'h1, {31'h0, fok});
    report_and_stop();
  end
endmodule
`default_nettype wire
